// ===== core/vspc_top.v
// Notes on behaviour
// - target above ceiling regulates at ceiling
// - ceiling 16-bit unsigned, resets 1.15x strap, capped at 5.5 V
// - ceiling never rescaled by target writes
// - margin high uses its setpoint, capped
// - margin low uses its setpoint, capped
// - slew only margin changes; max means instant
// - linear-11: exponent high, mantissa low
// - droop slope 0 to 40 mV/A lowers output
// - negative current raises output through droop
// - frequency is 1600 kHz over 12..80 divisor
// - group count bits 7:4, zero means sixteen
// - position bits 3:0, zero means sixteen
// - offset rounded pos*16/count times 22.5, wrapped
// - second phase is first plus 180 degrees
// - sense gain in milliohm, reset b2ae
// - sense offset in amperes, reset -1.5 A
// - voltage words use exponent minus thirteen
// - operation margin fields; others flag errors
`timescale 1ns/10ps
`default_nettype none
`include "vspc_consts.vh"
module vspc_top (
    input wire core_clk,
    input wire nrst,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] cmd_code,
    input wire [15:0] wr_data,
    input wire [15:0] strapped_voltage_setting,
    input wire [15:0] strap_slope,
    input wire [15:0] strap_fsw,
    input wire [15:0] strap_phase,
    input wire signed [15:0] iout_raw,
    input wire output_enabled,
    output reg [15:0] rd_data,
    output reg rd_valid,
    output reg cmd_error,
    output reg [15:0] vout_reg_q,
    output reg [6:0] fsw_div_q,
    output reg [3:0] phase0_q,
    output reg [3:0] phase1_q,
    output reg [15:0] phase0_mdeg_q,
    output reg signed [15:0] iout_cal_q
);
    reg [15:0] output_voltage_ceiling_q;
    reg [15:0] margin_high_setpoint_q;
    reg [15:0] margin_low_setpoint_q;
    reg [15:0] margin_slew_rate_q;
    reg [15:0] load_line_slope_q;
    reg [15:0] switching_frequency_q;
    reg [15:0] phase_spread_config_q;
    reg [15:0] current_sense_gain_q;
    reg [15:0] current_sense_offset_q;
    reg [15:0] output_voltage_target_q;
    reg [7:0] operation_q;
    reg strap_load_q;
    reg [15:0] strapped_voltage_setting_q;
    reg [15:0] slew_pos_q;
    reg [6:0] tick_cnt_q;
    reg margin_move_q;
    ///////////////////////////////////////////////////////////////////
    // strap scaling
    wire [25:0] ceil_prod = strapped_voltage_setting * `VSPC_SCALE_CEIL;
    wire [25:0] hi_prod = strapped_voltage_setting * `VSPC_SCALE_HI;
    wire [25:0] lo_prod = strapped_voltage_setting * `VSPC_SCALE_LO;
    wire [15:0] ceil_dflt = (ceil_prod[25:8] > {2'b00, `VSPC_CEIL_TOP}) ?
        `VSPC_CEIL_TOP : ceil_prod[23:8];
    ///////////////////////////////////////////////////////////////////
    // operation decode
    wire [1:0] op_unit = operation_q[7:6];
    wire [1:0] op_mrg = operation_q[5:4];
    wire op_ok_d = (wr_data[3:0] == 4'h0) && (wr_data[7:6] != 2'b11) &&
        ((wr_data[7:6] != `VSPC_OP_ON) ? (wr_data[5:4] == 2'b00) :
        (wr_data[5:4] != 2'b11));
    // requested level per margin state
    reg [15:0] req_level;
    always @* begin
        case (op_mrg)
            `VSPC_MRG_HI: req_level = margin_high_setpoint_q;
            `VSPC_MRG_LO: req_level = margin_low_setpoint_q;
            default: req_level = output_voltage_target_q;
        endcase
    end
    // clamp to ceiling, integer steps of 2^-13 V
    wire [15:0] capped = (req_level > output_voltage_ceiling_q) ?
        output_voltage_ceiling_q : req_level;
    ///////////////////////////////////////////////////////////////////
    // linear-11 decoding
    wire signed [31:0] slew_lsb_per_us;
    wire signed [31:0] slope_uv;
    wire signed [31:0] fsw_khz;
    // V/ms times 8.192 lsb/mV gives lsb per us, scale taken as 8
    vspc_lin11 u_slew (
        .word(margin_slew_rate_q),
        .scale(16'd8),
        .value(slew_lsb_per_us)
    );
    vspc_lin11 u_slope (
        .word(load_line_slope_q),
        .scale(16'd1000),
        .value(slope_uv)
    );
    vspc_lin11 u_fsw (
        .word(switching_frequency_q),
        .scale(16'd1),
        .value(fsw_khz)
    );
    wire slew_max = (margin_slew_rate_q == 16'h7bff);
    wire [15:0] slew_step = (slew_lsb_per_us < 32'sd1) ? 16'd1 :
        slew_lsb_per_us[15:0];
    ///////////////////////////////////////////////////////////////////
    // droop: micro-volts per amp times current, in 2^-13 V lsb
    wire signed [31:0] iout_w = iout_raw;
    wire signed [31:0] slope_cl = (slope_uv < 32'sd0) ? 32'sd0 :
        (slope_uv > 32'sd40000) ? 32'sd40000 : slope_uv;
    wire signed [47:0] droop_uv = slope_cl * iout_w;
    wire signed [47:0] droop_lsb = droop_uv / 48'sd122;
    wire signed [47:0] vout_drooped = $signed({32'd0, slew_pos_q}) -
        droop_lsb;
    ///////////////////////////////////////////////////////////////////
    // frequency divisor: nearest 1600/khz, bounded 12..80
    wire [31:0] fsw_pos = (fsw_khz < 32'sd20) ? 32'd20 : fsw_khz;
    wire [31:0] div_raw = (32'd1600 + (fsw_pos >> 1)) / fsw_pos;
    wire [6:0] div_cl = (div_raw < 32'd12) ? `VSPC_DIV_MIN :
        (div_raw > 32'd80) ? `VSPC_DIV_MAX : div_raw[6:0];
    ///////////////////////////////////////////////////////////////////
    // phase placement
    wire [4:0] grp_n = (phase_spread_config_q[7:4] == 4'h0) ?
        `VSPC_PH_FULL : {1'b0, phase_spread_config_q[7:4]};
    wire [4:0] grp_pos = (phase_spread_config_q[3:0] == 4'h0) ?
        `VSPC_PH_FULL : {1'b0, phase_spread_config_q[3:0]};
    wire [9:0] ph_num = {grp_pos, 4'h0} + {5'd0, grp_n[4:1]};
    wire [9:0] ph_units = ph_num / {5'd0, grp_n};
    wire [9:0] ph_wrap = (ph_units > 10'd16) ? ph_units - 10'd16 :
        ph_units;
    wire [3:0] ph0 = ph_wrap[3:0];
    wire [3:0] ph1 = ph0 + 4'd8;
    // wide product, 15 steps of 22.5 deg overflow 16 bits before the divide
    wire [31:0] ph_cdeg = ph0 * `VSPC_PH_STEP_MDEG / 32'd10;
    ///////////////////////////////////////////////////////////////////
    // command writes and strap load after reset release
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strap_load_q <= 1'b1;
            strapped_voltage_setting_q <= 16'h0000;
            output_voltage_ceiling_q <= 16'h0000;
            margin_high_setpoint_q <= 16'h0000;
            margin_low_setpoint_q <= 16'h0000;
            margin_slew_rate_q <= `VSPC_RST_SLEW;
            load_line_slope_q <= 16'h0000;
            switching_frequency_q <= 16'h0000;
            phase_spread_config_q <= 16'h0000;
            current_sense_gain_q <= `VSPC_RST_GAIN;
            current_sense_offset_q <= `VSPC_RST_OFFSET;
            output_voltage_target_q <= 16'h0000;
            operation_q <= 8'h00;
            cmd_error <= 1'b0;
        end else if (strap_load_q) begin
            strap_load_q <= 1'b0;
            strapped_voltage_setting_q <= strapped_voltage_setting;
            output_voltage_target_q <= strapped_voltage_setting;
            output_voltage_ceiling_q <= ceil_dflt;
            margin_high_setpoint_q <= hi_prod[23:8];
            margin_low_setpoint_q <= lo_prod[23:8];
            load_line_slope_q <= strap_slope;
            switching_frequency_q <= strap_fsw;
            phase_spread_config_q <= {8'h00, strap_phase[7:0]};
        end else begin
            cmd_error <= 1'b0;
            if (wr_en) begin
                case (cmd_code)
                    `VSPC_CMD_OPERATION: begin
                        if (op_ok_d)
                            operation_q <= wr_data[7:0];
                        else
                            cmd_error <= 1'b1;
                    end
                    // target write leaves the ceiling alone
                    `VSPC_CMD_VOUT_TARGET:
                        output_voltage_target_q <= wr_data;
                    `VSPC_CMD_CEILING: begin
                        if (wr_data > `VSPC_CEIL_TOP)
                            cmd_error <= 1'b1;
                        else
                            output_voltage_ceiling_q <= wr_data;
                    end
                    `VSPC_CMD_MARGIN_HI: margin_high_setpoint_q <= wr_data;
                    `VSPC_CMD_MARGIN_LO: margin_low_setpoint_q <= wr_data;
                    `VSPC_CMD_SLEW: margin_slew_rate_q <= wr_data;
                    `VSPC_CMD_SLOPE: load_line_slope_q <= wr_data;
                    `VSPC_CMD_FSW: begin
                        if (output_enabled)
                            cmd_error <= 1'b1;
                        else
                            switching_frequency_q <= wr_data;
                    end
                    `VSPC_CMD_PHASE:
                        phase_spread_config_q <= {8'h00, wr_data[7:0]};
                    `VSPC_CMD_GAIN: current_sense_gain_q <= wr_data;
                    `VSPC_CMD_OFFSET: current_sense_offset_q <= wr_data;
                    default: cmd_error <= 1'b1;
                endcase
            end
        end
    end
    ///////////////////////////////////////////////////////////////////
    // readback mux
    reg [15:0] rd_mux;
    always @* begin
        case (cmd_code)
            `VSPC_CMD_OPERATION: rd_mux = {8'h00, operation_q};
            `VSPC_CMD_VOUT_TARGET: rd_mux = output_voltage_target_q;
            `VSPC_CMD_CEILING: rd_mux = output_voltage_ceiling_q;
            `VSPC_CMD_MARGIN_HI: rd_mux = margin_high_setpoint_q;
            `VSPC_CMD_MARGIN_LO: rd_mux = margin_low_setpoint_q;
            `VSPC_CMD_SLEW: rd_mux = margin_slew_rate_q;
            `VSPC_CMD_SLOPE: rd_mux = load_line_slope_q;
            `VSPC_CMD_FSW: rd_mux = switching_frequency_q;
            `VSPC_CMD_PHASE: rd_mux = phase_spread_config_q;
            `VSPC_CMD_GAIN: rd_mux = current_sense_gain_q;
            `VSPC_CMD_OFFSET: rd_mux = current_sense_offset_q;
            default: rd_mux = 16'h0000;
        endcase
    end
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en)
                rd_data <= rd_mux;
        end
    end
    ///////////////////////////////////////////////////////////////////
    // setpoint tracking: margin moves slewed, others jump
    wire tick = (tick_cnt_q == 7'd0);
    wire margin_state = (op_unit == `VSPC_OP_ON) &&
        (op_mrg != `VSPC_MRG_NOM);
    wire unit_on = (op_unit == `VSPC_OP_ON) && output_enabled;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_q <= 7'd0;
            slew_pos_q <= 16'h0000;
            margin_move_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick ? 7'd124 : tick_cnt_q - 7'd1;
            // keep slewing after leaving margin until nominal is reached
            margin_move_q <= margin_state ||
                (margin_move_q && (slew_pos_q != capped));
            if (!unit_on || slew_max) begin
                slew_pos_q <= capped;
            end else if (margin_state || margin_move_q) begin
                if (tick) begin
                    if (capped > slew_pos_q + slew_step)
                        slew_pos_q <= slew_pos_q + slew_step;
                    else if (slew_pos_q > capped + slew_step)
                        slew_pos_q <= slew_pos_q - slew_step;
                    else
                        slew_pos_q <= capped;
                end
            end else begin
                slew_pos_q <= capped;
            end
        end
    end
    ///////////////////////////////////////////////////////////////////
    // derived outputs
    wire signed [31:0] gain_mohm_x1k;
    wire signed [31:0] offs_ma;
    vspc_lin11 u_gain (
        .word(current_sense_gain_q),
        .scale(16'd1000),
        .value(gain_mohm_x1k)
    );
    vspc_lin11 u_offs (
        .word(current_sense_offset_q),
        .scale(16'd1000),
        .value(offs_ma)
    );
    wire signed [31:0] gain_nz = (gain_mohm_x1k < 32'sd1) ? 32'sd1 :
        gain_mohm_x1k;
    // raw sense in microvolts over milliohm gives milliamps
    wire signed [31:0] iout_ma = (iout_w * 32'sd1000) / gain_nz -
        offs_ma;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vout_reg_q <= 16'h0000;
            fsw_div_q <= `VSPC_DIV_MIN;
            phase0_q <= 4'h0;
            phase1_q <= 4'h0;
            phase0_mdeg_q <= 16'h0000;
            iout_cal_q <= 16'sh0000;
        end else begin
            vout_reg_q <= (vout_drooped < 48'sd0) ? 16'h0000 :
                (vout_drooped > 48'sd65535) ? 16'hffff :
                vout_drooped[15:0];
            fsw_div_q <= div_cl;
            phase0_q <= ph0;
            phase1_q <= ph1;
            phase0_mdeg_q <= ph_cdeg[15:0];
            iout_cal_q <= iout_ma[15:0];
        end
    end
endmodule
`default_nettype wire

// ===== core/vspc_consts.vh
`ifndef VSPC_CONSTS_VH
`define VSPC_CONSTS_VH
// command codes of the block's registers
`define VSPC_CMD_OPERATION 8'h01
`define VSPC_CMD_VOUT_TARGET 8'h21
`define VSPC_CMD_CEILING 8'h24
`define VSPC_CMD_MARGIN_HI 8'h25
`define VSPC_CMD_MARGIN_LO 8'h26
`define VSPC_CMD_SLEW 8'h27
`define VSPC_CMD_SLOPE 8'h28
`define VSPC_CMD_FSW 8'h33
`define VSPC_CMD_PHASE 8'h37
`define VSPC_CMD_GAIN 8'h38
`define VSPC_CMD_OFFSET 8'h39
// fixed reset values
`define VSPC_RST_SLEW 16'hba00
`define VSPC_RST_GAIN 16'hb2ae
`define VSPC_RST_OFFSET 16'hbd00
// strap scale factors in 1/256 units: 1.15, 1.05, 0.95
`define VSPC_SCALE_CEIL 10'd294
`define VSPC_SCALE_HI 10'd269
`define VSPC_SCALE_LO 10'd243
// ceiling range top, 5.5 V at 2^-13
`define VSPC_CEIL_TOP 16'hb000
// operation fields
`define VSPC_OP_ON 2'b10
`define VSPC_MRG_NOM 2'b00
`define VSPC_MRG_LO 2'b01
`define VSPC_MRG_HI 2'b10
// switching frequency divisor limits
`define VSPC_DIV_MIN 7'd12
`define VSPC_DIV_MAX 7'd80
`define VSPC_FSW_BASE_KHZ 11'd1600
// phase units of 22.5 degrees
`define VSPC_PH_STEP_MDEG 16'd22500
`define VSPC_PH_FULL 5'd16
`define VSPC_PH_HALF 5'd8
// slew stepping: one step per 1 us tick (125 cycles)
`define VSPC_CLK_MHZ 125
`define VSPC_TICK_CYC (`VSPC_CLK_MHZ * 1)
`endif

// ===== core/vspc_lin11.v
`timescale 1ns/10ps
`default_nettype none
// linear-11 word times scale, result shifted to integer units
module vspc_lin11 (
    input wire [15:0] word,
    input wire [15:0] scale,
    output wire signed [31:0] value
);
    wire signed [4:0] expo;
    wire signed [10:0] mant;
    wire signed [31:0] prod;
    wire [4:0] nexp;
    // exponent high, mantissa low
    assign expo = word[15:11];
    assign mant = word[10:0];
    assign prod = mant * $signed({1'b0, scale});
    assign nexp = -expo;
    assign value = expo[4] ? (prod >>> nexp) : (prod <<< expo);
endmodule
`default_nettype wire

// ===== sim/vspc_host.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
// host side of the command port
module vspc_host (
    input wire logic core_clk,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] cmd_code,
    output logic [15:0] wr_data,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic cmd_error
);
    // idle bus at time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        cmd_code = 8'h00;
        wr_data = 16'h0000;
    end
    // one write, held over the taking edge
    task automatic put(input logic [7:0] c, input logic [15:0] d,
        output logic e);
        @(posedge core_clk);
        wr_en <= 1'b1;
        cmd_code <= c;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
        wr_data <= ~d; // stale data not left standing
        #1 e = cmd_error;
    endtask
    // one read, answer taken one edge later
    task automatic get(input logic [7:0] c, output logic [15:0] d);
        @(posedge core_clk);
        rd_en <= 1'b1;
        cmd_code <= c;
        @(posedge core_clk);
        rd_en <= 1'b0;
        cmd_code <= ~c;
        #1 d = rd_valid ? rd_data : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

// ===== sim/vspc_chk.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////
// port checker for the command block
module vspc_chk (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] wr_data,
    input wire logic output_enabled,
    input wire logic rd_valid,
    input wire logic cmd_error,
    input wire logic [6:0] fsw_div_q,
    input wire logic [3:0] phase0_q,
    input wire logic [3:0] phase1_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // write decodes
    wire w_ceil = wr_en && cmd_code == 8'h24;
    wire w_fsw = wr_en && cmd_code == 8'h33;
    wire w_op = wr_en && cmd_code == 8'h01;
    a_ceil_refuse: assert property (
        w_ceil && wr_data > 16'hb000 |=> cmd_error)
        else $error("ceiling above range accepted");
    a_ceil_accept: assert property (
        w_ceil && wr_data <= 16'hb000 |=> !cmd_error)
        else $error("ceiling in range refused");
    a_fsw_locked: assert property (
        w_fsw && output_enabled |=> cmd_error && $stable(fsw_div_q)
        ##1 $stable(fsw_div_q))
        else $error("frequency changed while output on");
    a_fsw_range: assert property (
        rd_en |-> fsw_div_q >= 7'd12 && fsw_div_q <= 7'd80)
        else $error("divisor out of range");
    a_phase_half: assert property (
        rd_en |-> phase1_q == phase0_q + 4'd8)
        else $error("second phase not half a turn later");
    a_op_bad: assert property (
        w_op && wr_data[7:4] == 4'hb |=> cmd_error)
        else $error("bad margin field accepted");
    a_op_unit_bad: assert property (
        w_op && wr_data[7:6] == 2'b11 |=> cmd_error)
        else $error("unlisted unit field accepted");
    a_op_good: assert property (
        w_op && wr_data[7:0] inside {8'h80, 8'h90, 8'ha0} |=> !cmd_error)
        else $error("valid operation refused");
    a_err_cause: assert property (
        cmd_error |-> $past(wr_en))
        else $error("error pulse without a write");
    c_fsw_locked: cover property (w_fsw && output_enabled);
    c_ceil_bad: cover property (w_ceil && wr_data > 16'hb000);
    c_read: cover property (rd_valid);
endmodule
bind vspc_top vspc_chk u_chk (.*);
`default_nettype wire

// ===== sim/vout_setpoint_phase_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "vspc_consts.vh"
module vout_setpoint_phase_config_tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic output_enabled = 1'b0;
    logic signed [15:0] iout_raw = 16'sh0000;
    logic [15:0] strapped_voltage_setting = 16'h2000;
    logic [15:0] strap_slope = 16'h0000;
    logic [15:0] strap_fsw = 16'h0064;
    logic [15:0] strap_phase = 16'h0041;
    logic wr_en, rd_en, rd_valid, cmd_error, er;
    logic [7:0] cmd_code;
    logic [15:0] wr_data, rd_data, vout_reg_q, phase0_mdeg_q, rv;
    logic [6:0] fsw_div_q;
    logic [3:0] phase0_q, phase1_q;
    logic signed [15:0] iout_cal_q;
    int n_mismatch = 0;
    int n_checks = 0;
    localparam int CE = 32'h2000 * `VSPC_SCALE_CEIL / 256;
    localparam int HI = 32'h2000 * `VSPC_SCALE_HI / 256;
    localparam int LO = 32'h2000 * `VSPC_SCALE_LO / 256;
    // written word, expected first phase
    localparam logic [31:0] PH [6] = '{32'hff41_0004, 32'h0043_000c,
        32'h0000_0000, 32'h0032_000b, 32'h0034_0005, 32'h0001_0001};
    vspc_top u_dut (.*);
    vspc_host u_host (.*);
    // 125 mhz clock
    always #4 core_clk = ~core_clk;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rchk(input logic [7:0] c, input logic [15:0] e);
        u_host.get(c, rv);
        check(rv, e);
    endtask
    task automatic wchk(input logic [7:0] c, input logic [15:0] d,
        input logic e);
        u_host.put(c, d, er);
        check({15'h0, er}, {15'h0, e});
    endtask
    // hang guard, tests need about 6k cycles
    initial begin
        cyc(40000);
        n_mismatch++;
        wrap_up();
    end
    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        cyc(4);
        rchk(8'h24, 16'(CE));
        rchk(8'h25, 16'(HI));
        rchk(8'h26, 16'(LO));
        rchk(8'h27, 16'hba00);
        rchk(8'h28, 16'h0000);
        rchk(8'h38, 16'hb2ae);
        rchk(8'h39, 16'hbd00);
        check(iout_cal_q, 16'h05dc);
        check({9'h0, fsw_div_q}, 16'h0010);
        wchk(8'h24, 16'hb001, 1'b1);
        wchk(8'h24, 16'hb000, 1'b0);
        wchk(8'h24, 16'h2800, 1'b0);
        wchk(8'h27, 16'h7bff, 1'b0);
        wchk(8'h21, 16'h3000, 1'b0);
        wchk(8'h01, 16'h0080, 1'b0);
        cyc(4);
        check(vout_reg_q, 16'h2800);
        wchk(8'h21, 16'h1000, 1'b0);
        rchk(8'h24, 16'h2800);
        wchk(8'h01, 16'h00a0, 1'b0);
        cyc(4);
        check(vout_reg_q, 16'(HI));
        wchk(8'h25, 16'h3000, 1'b0);
        cyc(4);
        check(vout_reg_q, 16'h2800);
        wchk(8'h01, 16'h0090, 1'b0);
        cyc(4);
        check(vout_reg_q, 16'(LO));
        wchk(8'h01, 16'h00b0, 1'b1);
        wchk(8'h01, 16'h00c0, 1'b1);
        wchk(8'h50, 16'h0000, 1'b1);
        // slew from a near margin level at the default rate, output on
        @(posedge core_clk);
        output_enabled <= 1'b1;
        wchk(8'h26, 16'h1100, 1'b0);
        cyc(4);
        wchk(8'h27, 16'hba00, 1'b0);
        wchk(8'h01, 16'h0080, 1'b0);
        cyc(4);
        check({15'h0, vout_reg_q > 16'h1000}, 16'h0001);
        cyc(6000);
        check(vout_reg_q, 16'h1000);
        // droop with sourced and sunk current
        wchk(8'h28, 16'h0014, 1'b0);
        @(posedge core_clk);
        iout_raw <= 16'sd1000;
        cyc(4);
        check({15'h0, vout_reg_q < 16'h1000}, 16'h0001);
        @(posedge core_clk);
        iout_raw <= -16'sd1000;
        cyc(4);
        check({15'h0, vout_reg_q > 16'h1000}, 16'h0001);
        // frequency only while output is off
        @(posedge core_clk);
        output_enabled <= 1'b0;
        wchk(8'h33, 16'h0032, 1'b0);
        cyc(2);
        check({9'h0, fsw_div_q}, 16'h0020);
        @(posedge core_clk);
        output_enabled <= 1'b1;
        wchk(8'h33, 16'h0064, 1'b1);
        rchk(8'h33, 16'h0032);
        @(posedge core_clk);
        output_enabled <= 1'b0;
        // phase placement table
        foreach (PH[i]) begin
            wchk(8'h37, PH[i][31:16], 1'b0);
            cyc(2);
            rchk(8'h37, {8'h00, PH[i][23:16]});
            check({12'h0, phase0_q}, PH[i][15:0]);
            check(phase0_mdeg_q, PH[i][15:0] * 16'd2250);
            check({12'h0, phase1_q}, {12'h0, PH[i][3:0] + 4'd8});
        end
        wrap_up();
    end
endmodule
`default_nettype wire
